// File: pkg/switch_strap_reset_control_regs.svh
`ifndef SWITCH_STRAP_RESET_CONTROL_REGS_SVH
`define SWITCH_STRAP_RESET_CONTROL_REGS_SVH
// Contract
// R1: gpio 7 alternate function is the active-low general event output.
// R2: gpio 9 alternate function is the active-low reset for downstream port 3.
// R3: gpio 10 alternate function is the active-low reset for downstream port 5.
// R4: gpio 0 and 1 alternate functions reset downstream ports 2 and 4.
// R5: auxiliary power is never used while the aux disable input is active.
// R6: downstream common-clock strap seeds every downstream slot clock bit; software may overwrite.
// R7: upstream common-clock strap seeds the upstream slot clock bit; software may overwrite.
// R8: slow strap picks 100 kHz config bus, else 400 kHz; nothing overrides it.
// R9: fundamental reset resets all internal logic and starts a link fundamental reset; the test port, wake and aux logic ignore it.
// R10: halt strap during reset: finish reset procedure, stay held, management buses alive.
// R11: leave the halted state only when the halt bit is cleared by a bus master.
// R12: mode strap: 0 normal, 1 normal after eeprom load, others reserved.
// R13: wake pin is input or output as the wake direction bit says.
// R14: test clock runs independently of the system clock and clocks the scan logic.
// R15: test data output is tri-stated unless data is being shifted out.
// R16: test reset low resets the test controller asynchronously.
// R17: board holds test reset low in functional operation.
// R18: straps are sampled at reset release and held until the next reset.

// ---------------------------------------------------------------
// general-purpose pin alternate functions
// ---------------------------------------------------------------
`define GPIO_COUNT 11
`define GPIO_PORT2_RST 0
`define GPIO_PORT4_RST 1
`define GPIO_EVENT 7
`define GPIO_PORT3_RST 9
`define GPIO_PORT5_RST 10
`define GPIO_ALT_MASK 11'h683

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_MODE 3'h0
`define RST_SLOT_CLK 1'b1
`define RST_HALT_BIT 1'b0
`define MODE_NORMAL 3'h0
`define MODE_EEPROM 3'h1

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_FREQ_KHZ 100000
`define CFG_BUS_SLOW_KHZ 100
`define CFG_BUS_FAST_KHZ 400
`define CFG_BUS_SLOW_CYCLES (`CLK_FREQ_KHZ / `CFG_BUS_SLOW_KHZ)
`define CFG_BUS_FAST_CYCLES (`CLK_FREQ_KHZ / `CFG_BUS_FAST_KHZ)
`define RESET_PROC_CYCLES 16
`define TAP_IR_CAPTURE 2'h1

`endif

// File: pkg/switch_strap_pkg.sv
package switch_strap_pkg;
    typedef enum logic [2:0] {
        SEQ_RESET  = 3'b000,
        SEQ_INIT   = 3'b001,
        SEQ_EEPROM = 3'b010,
        SEQ_HALT   = 3'b011,
        SEQ_RUN    = 3'b100
    } seq_state_t;

    typedef enum logic [3:0] {
        TAP_RESET   = 4'b0000,
        TAP_IDLE    = 4'b0001,
        TAP_SEL_DR  = 4'b0010,
        TAP_CAP_DR  = 4'b0011,
        TAP_SH_DR   = 4'b0100,
        TAP_EX1_DR  = 4'b0101,
        TAP_PAU_DR  = 4'b0110,
        TAP_EX2_DR  = 4'b0111,
        TAP_UPD_DR  = 4'b1000,
        TAP_SEL_IR  = 4'b1001,
        TAP_CAP_IR  = 4'b1010,
        TAP_SH_IR   = 4'b1011,
        TAP_EX1_IR  = 4'b1100,
        TAP_PAU_IR  = 4'b1101,
        TAP_EX2_IR  = 4'b1110,
        TAP_UPD_IR  = 4'b1111
    } tap_state_t;
endpackage

// File: logic/test_access_port.sv
`timescale 1ns/1ps
`include "switch_strap_reset_control_regs.svh"
module test_access_port
    import switch_strap_pkg::*;
(
    input wire logic test_clk,
    input wire logic test_rst_n,
    input wire logic test_mode_sel,
    input wire logic test_data_in,
    output logic test_data_out_q,
    output logic test_data_out_oe_n_q
);
    tap_state_t state_q, state_d;
    logic [1:0] ir_q;
    logic bypass_q;

    // ----------
    // controller state walk on the test clock only
    // ----------
    always_comb begin
        unique case (state_q)
            TAP_RESET: state_d = test_mode_sel ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: state_d = test_mode_sel ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: state_d = test_mode_sel ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: state_d = test_mode_sel ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: state_d = test_mode_sel ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: state_d = test_mode_sel ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: state_d = test_mode_sel ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: state_d = test_mode_sel ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: state_d = test_mode_sel ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: state_d = test_mode_sel ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: state_d = test_mode_sel ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: state_d = test_mode_sel ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: state_d = test_mode_sel ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: state_d = test_mode_sel ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: state_d = test_mode_sel ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: state_d = test_mode_sel ? TAP_SEL_DR : TAP_IDLE;
        endcase
    end

    // test reset acts with no clock at all [R16]
    always_ff @(posedge test_clk or negedge test_rst_n) begin // [R14]
        if (!test_rst_n) begin
            state_q <= TAP_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------
    // shift paths: only a bypass cell behind the instruction register
    // ----------
    always_ff @(posedge test_clk or negedge test_rst_n) begin
        if (!test_rst_n) begin // [R16]
            ir_q <= `TAP_IR_CAPTURE;
            bypass_q <= 1'b0;
        end else begin
            if (state_q == TAP_CAP_IR) begin
                ir_q <= `TAP_IR_CAPTURE;
            end else if (state_q == TAP_SH_IR) begin
                ir_q <= {test_data_in, ir_q[1]};
            end
            if (state_q == TAP_CAP_DR) begin
                bypass_q <= 1'b0;
            end else if (state_q == TAP_SH_DR) begin
                bypass_q <= test_data_in;
            end
        end
    end

    // output changes on the falling edge, floated outside shift states
    always_ff @(negedge test_clk or negedge test_rst_n) begin
        if (!test_rst_n) begin
            test_data_out_q <= 1'b0;
            test_data_out_oe_n_q <= 1'b1;
        end else begin
            test_data_out_q <= (state_q == TAP_SH_IR) ? ir_q[0] : bypass_q;
            test_data_out_oe_n_q <= !((state_q == TAP_SH_IR) || (state_q == TAP_SH_DR)); // [R15]
        end
    end
endmodule // test_access_port

// File: logic/switch_strap_reset_control.sv
`timescale 1ns/1ps
`include "switch_strap_reset_control_regs.svh"
module switch_strap_reset_control
    import switch_strap_pkg::*;
#(
    parameter int RESET_PROC_CYCLES = `RESET_PROC_CYCLES
)
(
    input wire logic clk,
    input wire logic sys_rst,
    // system pins and straps
    input wire logic fundamental_reset_n,
    input wire logic halt_after_reset,
    input wire logic [2:0] switch_mode_strap,
    input wire logic common_clock_downstream_strap,
    input wire logic common_clock_upstream_strap,
    input wire logic config_bus_slow_strap,
    input wire logic aux_power_disable_n,
    // control from the register side
    input wire logic halt_bit_clear,
    input wire logic eeprom_load_done,
    input wire logic [3:0] ds_slot_clock_wr,
    input wire logic ds_slot_clock_wr_data,
    input wire logic us_slot_clock_wr,
    input wire logic us_slot_clock_wr_data,
    input wire logic aux_power_request,
    input wire logic general_event_req,
    input wire logic [3:0] port_reset_req,
    input wire logic wake_direction_bit,
    input wire logic wake_assert_req,
    // general-purpose pins
    input wire logic [10:0] gpio_alt_sel,
    input wire logic [10:0] gpio_dir_out,
    input wire logic [10:0] gpio_data_out,
    input wire logic [10:0] gpio_in,
    output logic [10:0] gpio_o_q,
    output logic [10:0] gpio_oe_n_q,
    // wake pin, open drain
    input wire logic wake_pin_n_in,
    output logic wake_pin_n_o_q,
    output logic wake_pin_n_oe_n_q,
    output logic wake_detected_q,
    // status and control to the rest of the switch
    output seq_state_t seq_state_q,
    output logic core_reset_q,
    output logic link_fundamental_reset_q,
    output logic mgmt_bus_enable_q,
    output logic halt_bit_q,
    output logic [2:0] switch_mode_q,
    output logic eeprom_load_req_q,
    output logic mode_reserved_q,
    output logic [3:0] ds_slot_clock_cfg_q,
    output logic us_slot_clock_cfg_q,
    output logic config_bus_slow_q,
    output logic config_bus_tick_q,
    output logic aux_power_use_q,
    output logic [10:0] gpio_in_q,
    // test access port
    input wire logic test_clk,
    input wire logic test_rst_n,
    input wire logic test_mode_sel,
    input wire logic test_data_in,
    output logic test_data_out_q,
    output logic test_data_out_oe_n_q
);
    // ----------
    // constants
    // ----------
    localparam logic [10:0] ALT_MASK = `GPIO_ALT_MASK;
    localparam logic [9:0] SLOW_LAST = 10'(`CFG_BUS_SLOW_CYCLES - 1);
    localparam logic [9:0] FAST_LAST = 10'(`CFG_BUS_FAST_CYCLES - 1);
    localparam int PROC_W = $clog2(RESET_PROC_CYCLES + 1);
    localparam logic [PROC_W-1:0] PROC_LAST = PROC_W'(RESET_PROC_CYCLES - 1);

    // mode decode is needed by the sequencer and by the status flags
    function automatic logic mode_wants_eeprom(input logic [2:0] mode);
        mode_wants_eeprom = (mode == `MODE_EEPROM);
    endfunction

    function automatic logic mode_is_reserved(input logic [2:0] mode);
        mode_is_reserved = (mode != `MODE_NORMAL) && (mode != `MODE_EEPROM);
    endfunction

    // ----------
    // sequencer signals
    // ----------
    seq_state_t seq_state_d;
    logic [PROC_W-1:0] proc_cnt_q;
    logic [PROC_W-1:0] proc_cnt_d;
    logic strap_capture;
    logic proc_done;
    logic in_reset;
    logic not_running;
    logic halt_bit_d;

    // the first cycle with the pin released is the strap sample point
    assign in_reset = !fundamental_reset_n;
    assign strap_capture = (seq_state_q == SEQ_RESET) && fundamental_reset_n; // [R18]
    assign proc_done = (proc_cnt_q == PROC_LAST);
    assign not_running = (seq_state_d != SEQ_RUN);

    // ----------
    // reset sequencer
    // ----------
    // pin reset takes priority over every other state [R9]
    always_comb begin
        seq_state_d = seq_state_q;
        unique case (seq_state_q)
            SEQ_RESET: begin
                if (fundamental_reset_n) begin
                    seq_state_d = SEQ_INIT;
                end
            end
            SEQ_INIT: begin
                if (proc_done) begin
                    if (mode_wants_eeprom(switch_mode_q)) begin // [R12]
                        seq_state_d = SEQ_EEPROM;
                    end else if (halt_bit_q) begin // [R10]
                        seq_state_d = SEQ_HALT;
                    end else begin
                        seq_state_d = SEQ_RUN;
                    end
                end
            end
            SEQ_EEPROM: begin
                if (eeprom_load_done) begin
                    seq_state_d = halt_bit_q ? SEQ_HALT : SEQ_RUN; // [R10]
                end
            end
            SEQ_HALT: begin
                if (!halt_bit_q) begin // [R11]
                    seq_state_d = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                seq_state_d = SEQ_RUN;
            end
            default: begin
                seq_state_d = SEQ_RESET;
            end
        endcase
        if (in_reset) begin
            seq_state_d = SEQ_RESET; // [R9]
        end
    end

    // reset procedure length counter, idle outside the init state
    assign proc_cnt_d = (seq_state_q == SEQ_INIT && !proc_done) ? proc_cnt_q + PROC_W'(1) : '0;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            seq_state_q <= SEQ_RESET;
            proc_cnt_q <= '0;
        end else begin
            seq_state_q <= seq_state_d;
            proc_cnt_q <= proc_cnt_d;
        end
    end

    // ----------
    // strap capture and halt bit
    // ----------
    // the halt bit is loaded only at strap capture, which wins over a clear in the same cycle
    assign halt_bit_d = strap_capture ? halt_after_reset :
                        (halt_bit_clear && !in_reset) ? 1'b0 : halt_bit_q; // [R11]

    // straps held stable until the next pin reset [R18]
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            halt_bit_q <= `RST_HALT_BIT;
            switch_mode_q <= `RST_MODE;
            config_bus_slow_q <= 1'b0;
        end else begin
            halt_bit_q <= halt_bit_d; // [R10]
            if (strap_capture) begin
                switch_mode_q <= switch_mode_strap; // [R12]
                config_bus_slow_q <= config_bus_slow_strap; // [R8]
            end
        end
    end

    // ----------
    // mode flags and reset outputs
    // ----------
    // buses stay alive in halt so software can reach registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_reset_q <= 1'b1;
            link_fundamental_reset_q <= 1'b1;
            mgmt_bus_enable_q <= 1'b0;
            eeprom_load_req_q <= 1'b0;
            mode_reserved_q <= 1'b0;
        end else begin
            core_reset_q <= not_running; // [R9] [R10]
            link_fundamental_reset_q <= (seq_state_d == SEQ_RESET); // [R9]
            mgmt_bus_enable_q <= (seq_state_d != SEQ_RESET); // [R10]
            eeprom_load_req_q <= (seq_state_d == SEQ_EEPROM); // [R12]
            mode_reserved_q <= mode_is_reserved(switch_mode_q) && !in_reset; // [R12]
        end
    end

    // ----------
    // slot clock configuration bits
    // ----------
    // writes are ignored while the pin holds reset; the strap then wins
    generate
        for (genvar p = 0; p < 4; p++) begin : g_ds_slot
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    ds_slot_clock_cfg_q[p] <= `RST_SLOT_CLK;
                end else if (strap_capture) begin
                    ds_slot_clock_cfg_q[p] <= common_clock_downstream_strap; // [R6]
                end else if (ds_slot_clock_wr[p] && !in_reset) begin
                    ds_slot_clock_cfg_q[p] <= ds_slot_clock_wr_data; // [R6]
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            us_slot_clock_cfg_q <= `RST_SLOT_CLK;
        end else if (strap_capture) begin
            us_slot_clock_cfg_q <= common_clock_upstream_strap; // [R7]
        end else if (us_slot_clock_wr && !in_reset) begin
            us_slot_clock_cfg_q <= us_slot_clock_wr_data; // [R7]
        end
    end

    // ----------
    // configuration bus bit clock
    // ----------
    // rate comes from the captured strap only; no port can change it
    logic [9:0] bus_cnt_q;
    logic [9:0] bus_last;
    logic bus_wrap;

    assign bus_last = config_bus_slow_q ? SLOW_LAST : FAST_LAST; // [R8]
    assign bus_wrap = (bus_cnt_q >= bus_last);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_cnt_q <= '0;
            config_bus_tick_q <= 1'b0;
        end else if (!mgmt_bus_enable_q) begin
            bus_cnt_q <= '0;
            config_bus_tick_q <= 1'b0;
        end else begin
            bus_cnt_q <= bus_wrap ? 10'h000 : bus_cnt_q + 10'h001;
            config_bus_tick_q <= bus_wrap; // [R8]
        end
    end

    // ----------
    // auxiliary power
    // ----------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aux_power_use_q <= 1'b0;
        end else begin
            aux_power_use_q <= aux_power_request && aux_power_disable_n; // [R5]
        end
    end

    // ----------
    // general-purpose pins and their alternate functions
    // ----------
    // downstream resets also follow the switch's own reset
    logic [3:0] port_rst_n;
    logic [10:0] alt_value;
    logic [10:0] alt_active;

    assign port_rst_n = ~(port_reset_req | {4{core_reset_q}});
    assign alt_active = gpio_alt_sel & ALT_MASK;

    always_comb begin
        alt_value = 11'h7FF;
        alt_value[`GPIO_PORT2_RST] = port_rst_n[0]; // [R4]
        alt_value[`GPIO_PORT4_RST] = port_rst_n[2]; // [R4]
        alt_value[`GPIO_PORT3_RST] = port_rst_n[1]; // [R2]
        alt_value[`GPIO_PORT5_RST] = port_rst_n[3]; // [R3]
        alt_value[`GPIO_EVENT] = !general_event_req; // [R1]
    end

    // an alternate function always drives; plain pins follow their direction
    generate
        for (genvar i = 0; i < `GPIO_COUNT; i++) begin : g_gpio
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    gpio_o_q[i] <= 1'b1;
                    gpio_oe_n_q[i] <= 1'b1;
                    gpio_in_q[i] <= 1'b1;
                end else begin
                    gpio_o_q[i] <= alt_active[i] ? alt_value[i] : gpio_data_out[i]; // [R1] [R2] [R3] [R4]
                    gpio_oe_n_q[i] <= !(alt_active[i] || gpio_dir_out[i]);
                    gpio_in_q[i] <= gpio_in[i];
                end
            end
        end
    endgenerate

    // ----------
    // wake pin
    // ----------
    // open drain: only ever pulls low, and only when set as an output
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wake_pin_n_o_q <= 1'b0;
            wake_pin_n_oe_n_q <= 1'b1;
            wake_detected_q <= 1'b0;
        end else begin
            wake_pin_n_o_q <= 1'b0;
            wake_pin_n_oe_n_q <= !(wake_direction_bit && wake_assert_req); // [R13]
            wake_detected_q <= !wake_direction_bit && !wake_pin_n_in; // [R13]
        end
    end

    // ----------
    // test access port, on its own clock with no crossing
    // ----------
    // board ties test reset low in normal use, holding this idle [R17]
    test_access_port u_tap (
        .test_clk(test_clk),
        .test_rst_n(test_rst_n),
        .test_mode_sel(test_mode_sel),
        .test_data_in(test_data_in),
        .test_data_out_q(test_data_out_q),
        .test_data_out_oe_n_q(test_data_out_oe_n_q)
    );
endmodule // switch_strap_reset_control

// File: dv/strap_checker_asserts.sv
`timescale 1ns/1ps
module strap_checker
    import switch_strap_pkg::*;
(
    input logic clk,
    input logic sys_rst,
    input logic fundamental_reset_n,
    input logic general_event_req,
    input logic [3:0] port_reset_req,
    input logic [10:0] gpio_alt_sel,
    input logic [10:0] gpio_o_q,
    input logic aux_power_disable_n,
    input logic aux_power_use_q,
    input seq_state_t seq_state_q,
    input logic core_reset_q,
    input logic link_fundamental_reset_q,
    input logic mgmt_bus_enable_q,
    input logic halt_bit_q,
    input logic config_bus_slow_q,
    input logic [2:0] switch_mode_q,
    input logic test_rst_n,
    input logic test_data_out_oe_n_q
);
    // ----------
    // helper: pins are only checked against requests outside pin reset
    // ----------
    logic live_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            live_q <= 1'b0;
        end else begin
            live_q <= fundamental_reset_n && seq_state_q != SEQ_RESET;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ----------
    // properties
    // ----------
    a_event_pin: assert property (
        live_q && $past(gpio_alt_sel[7]) |-> gpio_o_q[7] == !$past(general_event_req))
        else $error("event pin wrong");
    a_port3_pin: assert property (live_q && $past(gpio_alt_sel[9] && port_reset_req[1]) |-> !gpio_o_q[9])
        else $error("port3 reset pin wrong");
    a_aux_off: assert property (!$past(aux_power_disable_n) |-> !aux_power_use_q)
        else $error("aux power used while disabled");
    a_pin_reset: assert property (
        !fundamental_reset_n |=> seq_state_q == SEQ_RESET && core_reset_q && link_fundamental_reset_q)
        else $error("pin reset not taken");
    a_halt_held: assert property (seq_state_q == SEQ_HALT |-> core_reset_q && mgmt_bus_enable_q)
        else $error("halt state not held");
    a_halt_exit: assert property (
        seq_state_q == SEQ_HALT && $fell(halt_bit_q) |=> seq_state_q == (fundamental_reset_n ? SEQ_RUN : SEQ_RESET))
        else $error("halt exit late");
    a_tdo_reset: assert property (!test_rst_n |-> test_data_out_oe_n_q)
        else $error("test output driven in reset");
    a_straps_hold: assert property (
        seq_state_q != SEQ_RESET && $past(seq_state_q) != SEQ_RESET |-> $stable({config_bus_slow_q, switch_mode_q}))
        else $error("straps changed");
    c_halt: cover property (seq_state_q == SEQ_HALT);
    c_eeprom: cover property (seq_state_q == SEQ_EEPROM);
    c_port3: cover property (live_q && !gpio_o_q[9]);
endmodule // strap_checker

bind switch_strap_reset_control strap_checker u_strap_checker (.*);

// File: dv/board_model.sv
`timescale 1ns/1ps
module board_model (
    input wire logic wake_pin_n_o_q,
    input wire logic wake_pin_n_oe_n_q,
    input wire logic ext_wake_n,
    input wire logic scan_en,
    output logic wake_pin_n_in,
    output logic test_rst_n
);
    // open-drain wake line with pull-up; any party may pull it low
    assign wake_pin_n_in = (wake_pin_n_oe_n_q || wake_pin_n_o_q) && ext_wake_n;
    // board keeps the test port in reset unless a tester takes over
    assign test_rst_n = scan_en;
endmodule // board_model

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import switch_strap_pkg::*;
    logic clk, sys_rst, fundamental_reset_n, halt_after_reset, common_clock_downstream_strap;
    logic common_clock_upstream_strap, config_bus_slow_strap, aux_power_disable_n, halt_bit_clear;
    logic eeprom_load_done, ds_slot_clock_wr_data, us_slot_clock_wr, us_slot_clock_wr_data, aux_power_request;
    logic general_event_req, wake_direction_bit, wake_assert_req, wake_pin_n_in, wake_pin_n_o_q, scan_en;
    logic test_clk, test_rst_n, test_mode_sel, test_data_in, test_data_out_q, test_data_out_oe_n_q, ext_wake_n;
    logic wake_pin_n_oe_n_q, wake_detected_q, core_reset_q, link_fundamental_reset_q, mgmt_bus_enable_q;
    logic halt_bit_q, eeprom_load_req_q, mode_reserved_q, us_slot_clock_cfg_q, config_bus_slow_q;
    logic config_bus_tick_q, aux_power_use_q, e, ap, wd, w;
    logic [2:0] switch_mode_strap, switch_mode_q, sv, md;
    logic [3:0] ds_slot_clock_wr, port_reset_req, ds_slot_clock_cfg_q, p;
    logic [10:0] gpio_alt_sel, gpio_dir_out, gpio_data_out, gpio_in, gpio_o_q, gpio_oe_n_q, gpio_in_q, a;
    seq_state_t seq_state_q;
    int n_fail = 0, n_checks = 0, i, m;
    switch_strap_reset_control u_switch_strap_reset_control (.*);
    board_model u_board_model (.*);
    // ----------
    // clocks: test clock free-running, unrelated in phase
    // ----------
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        test_clk = 0;
        forever #18.5 test_clk = ~test_clk;
    end
    // ----------
    // helpers
    // ----------
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one draw covers every free input; straps change too, to prove they are held
    task automatic shake();
        {aux_power_disable_n, aux_power_request, general_event_req, port_reset_req, wake_direction_bit} = 8'($urandom);
        {wake_assert_req, ext_wake_n, test_data_in, halt_after_reset, switch_mode_strap} = 7'($urandom);
        {common_clock_downstream_strap, common_clock_upstream_strap, config_bus_slow_strap} = 3'($urandom);
        {gpio_alt_sel, gpio_dir_out, ds_slot_clock_wr_data, us_slot_clock_wr_data} = 24'($urandom);
        {gpio_data_out, gpio_in} = 22'($urandom);
    endtask
    // alternate pin levels while the core is running
    function automatic logic [10:0] alt_val(input logic [3:0] pr, input logic ev);
        alt_val = {!pr[3], !pr[1], 1'b1, !ev, 5'h1F, !pr[2], !pr[0]};
    endfunction
    initial begin
        #1000000;
        n_fail++;
        results();
    end
    // ----------
    // main sequence
    // ----------
    initial begin
        void'($urandom(32'hA21E));
        {sys_rst, fundamental_reset_n, halt_bit_clear, eeprom_load_done} = 4'h8;
        {ds_slot_clock_wr, us_slot_clock_wr, scan_en, test_mode_sel} = 7'h01;
        shake();
        step(5);
        sys_rst = 0;
        // modes 0, 1, 2 and 7 once; the first boot also halts and writes slot bits
        for (m = 0; m < 4; m++) begin
            md = (m == 3) ? 3'h7 : 3'(m);
            w = (m == 0);
            shake();
            halt_after_reset = w;
            switch_mode_strap = md;
            fundamental_reset_n = 0;
            step(3);
            fundamental_reset_n = 1;
            step(1);
            sv = {common_clock_downstream_strap, common_clock_upstream_strap, config_bus_slow_strap};
            check({ds_slot_clock_cfg_q, us_slot_clock_cfg_q, config_bus_slow_q}, {{4{sv[2]}}, sv[1:0]});
            step(16);
            check({eeprom_load_req_q, mode_reserved_q}, {md == 1, md > 1});
            eeprom_load_done = (md == 1);
            if (w) begin
                check({core_reset_q, mgmt_bus_enable_q, seq_state_q}, {2'b11, SEQ_HALT});
                {ds_slot_clock_wr, us_slot_clock_wr, halt_bit_clear} = 6'h0B;
                {ds_slot_clock_wr_data, us_slot_clock_wr_data} = ~sv[2:1];
            end
            step(1);
            {ds_slot_clock_wr, us_slot_clock_wr, halt_bit_clear, eeprom_load_done} = 7'h00;
            for (i = 0; i < 50 && seq_state_q !== SEQ_RUN; i++) step(1);
            check({core_reset_q, seq_state_q}, {1'b0, SEQ_RUN});
            if (seq_state_q !== SEQ_RUN) results();
            for (i = 0; i < 1100 && config_bus_tick_q !== 1'b1; i++) step(1);
            for (i = 1; i < 1100 && config_bus_tick_q !== 1'b1 || i == 1; i++) step(1);
            check(11'(i - 1), sv[0] ? 11'h3E8 : 11'h0FA);
            shake();
            step(2);
            check({ds_slot_clock_cfg_q, us_slot_clock_cfg_q, config_bus_slow_q, switch_mode_q},
                  {{4{sv[2]}} ^ {2'b00, w, 1'b0}, sv[1] ^ w, sv[0], md});
        end
        // random pin traffic in run state; wake line level follows the last pull request
        wd = wake_direction_bit & wake_assert_req;
        for (i = 0; i < 40; i++) begin
            shake();
            {a, p, e} = {gpio_alt_sel & 11'h683, port_reset_req, general_event_req};
            ap = aux_power_request & aux_power_disable_n;
            w = !wake_direction_bit && (wd || !ext_wake_n);
            wd = wake_direction_bit & wake_assert_req;
            step(1);
            check(gpio_o_q, (alt_val(p, e) & a) | (gpio_data_out & ~a));
            check(gpio_oe_n_q, ~(a | gpio_dir_out));
            check({aux_power_use_q, wake_pin_n_oe_n_q}, {ap, !wd});
            check({wake_detected_q, wake_pin_n_o_q}, {w, 1'b0});
            check(gpio_in_q, gpio_in);
        end
        // test port: reset, walk to shift-IR on the test clock, abort by reset
        check(test_data_out_oe_n_q, 1);
        scan_en = 1;
        for (i = 0; i < 5; i++) begin
            @(posedge test_clk);
            #1;
            test_mode_sel = i[0] ^ i[1];
        end
        @(posedge test_clk);
        @(negedge test_clk);
        #1;
        check({test_data_out_oe_n_q, test_data_out_q}, 2'b01);
        scan_en = 0;
        #1;
        check(test_data_out_oe_n_q, 1);
        results();
    end
endmodule // tb_top
